/* nand_init_pkg.sv */
// constants, register map and state type for the flash target init block
// assumes a 250 MHz system clock; all users refer to names as nand_init_pkg::name
package nand_init_pkg;
   // target commands and feature addresses
   localparam logic [7:0] CMD_RESET         = 8'hFF;
   localparam logic [7:0] CMD_READ_STATUS   = 8'h70;
   localparam logic [7:0] CMD_SET_FEATURES  = 8'hEF;
   localparam logic [7:0] CMD_VOLUME_SELECT = 8'hE1;
   localparam logic [7:0] FEAT_TIMING       = 8'h01;
   localparam logic [7:0] FEAT_VOLUME_CFG   = 8'h58;
   localparam logic [3:0] TIMING_MODE0      = 4'h0;
   localparam int         STATUS_READY_BIT  = 6;
   // register byte addresses
   localparam int         REG_AW            = 4;
   localparam logic [3:0] REG_ECC_INFO      = 4'h0;
   localparam logic [3:0] REG_END_CYCLES    = 4'h4;
   localparam logic [3:0] REG_END_CODE      = 4'h8;
   localparam logic [3:0] REG_TARGET        = 4'hC;
   // field positions
   localparam int         ECC_CWSIZE_LSB    = 8;
   localparam int         ECC_BADMAX_LSB    = 16;
   localparam int         END_EXP_LSB       = 8;
   localparam int         END_BUSY_BIT      = 16;
   localparam int         END_OVF_BIT       = 17;
   localparam int         TGT_SEQ_BIT       = 4;
   localparam int         TGT_CHAIN_BIT     = 5;
   localparam int         TGT_VOL_LSB       = 8;
   localparam int         TGT_TIMING_LSB    = 16;
   // reset values
   localparam logic [31:0] ECC_INFO_RST     = 32'h0000_0000;
   localparam logic [31:0] END_CYCLES_RST   = 32'h0000_0000;
   localparam logic [7:0]  VOLUME_RST       = 8'h00;
   // arithmetic for the endurance encoder
   localparam logic [31:0] DECIMAL_RADIX    = 32'h0000_000A;
   localparam logic [31:0] VALUE_BYTE_MAX   = 32'h0000_00FF;
   // timing
   localparam int          CLK_PERIOD_NS    = 4;
   localparam int          RESET_BUSY_NS    = 5000;
   localparam int          FEAT_SETTLE_NS   = 1000;
   localparam int          RESET_BUSY_CYC   = (RESET_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          FEAT_SETTLE_CYC  = (FEAT_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          CNT_W            = 16;

   typedef enum logic [2:0] {
      ST_POWERON,
      ST_WAIT_SEQ,
      ST_RESETTING,
      ST_READY,
      ST_SETTLING,
      ST_DESELECTED,
      ST_SELECTED
   } tgt_state_t;
endpackage

/* endurance_if.sv */
// handshake between the register file and the endurance encoder
// assumes both ends run on clk_sys
`timescale 1ns/1ps
`default_nettype none
interface endurance_if;
   logic        start;
   logic [31:0] cycles;
   logic        busy;
   logic [7:0]  value;
   logic [7:0]  exponent;
   logic        ovf;
   modport enc (input start, input cycles, output busy, output value, output exponent,
                output ovf);
   modport ctl (output start, output cycles, input busy, input value, input exponent,
                input ovf);
endinterface
`default_nettype wire

/* endurance_encoder.sv */
// turns a raw cycle count into value and decimal exponent bytes
// assumes start is a one-cycle pulse; a start while busy restarts the encode
`timescale 1ns/1ps
`default_nettype none
module endurance_encoder
(
   // clock and reset
   input  wire logic    clk_sys,
   input  wire logic    reset,
   // encoder port
   endurance_if.enc     e
);
   logic [31:0] cur_r;
   logic [7:0]  exp_r;
   logic        busy_r;
   logic [31:0] src_r;
   logic [7:0]  value_r;
   logic [7:0]  exp_out_r;
   logic        ovf_r;

   wire         divisible = (cur_r != '0) && ((cur_r % nand_init_pkg::DECIMAL_RADIX) == '0);
   wire  [31:0] cur_div   = cur_r / nand_init_pkg::DECIMAL_RADIX;

   // strip factors of ten one per cycle so the value byte ends smallest
   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         cur_r     <= '0;
         exp_r     <= '0;
         busy_r    <= 1'b0;
         src_r     <= '0;
         value_r   <= '0;
         exp_out_r <= '0;
         ovf_r     <= 1'b0;
      end
      else if (e.start)
      begin
         cur_r  <= e.cycles;
         src_r  <= e.cycles;
         exp_r  <= '0;
         busy_r <= 1'b1;
      end
      else if (busy_r && divisible)
      begin
         cur_r <= cur_div;
         exp_r <= exp_r + 8'h01;
      end
      else if (busy_r)
      begin
         busy_r    <= 1'b0;
         value_r   <= cur_r[7:0];
         exp_out_r <= exp_r;
         ovf_r     <= cur_r > nand_init_pkg::VALUE_BYTE_MAX;
      end
   end

   assign e.busy     = busy_r;
   assign e.value    = value_r;
   assign e.exponent = exp_out_r;
   assign e.ovf      = ovf_r;

   property p_value_smallest;
      @(posedge clk_sys) disable iff (reset)
      $fell(busy_r) |-> (value_r == 8'h00) || ovf_r ||
                        (({24'h000000, value_r} % nand_init_pkg::DECIMAL_RADIX) != '0);
   endproperty
   a_value_smallest: assert property (p_value_smallest)
      else $error("endurance value byte still divisible by ten");

   property p_no_factor_left;
      @(posedge clk_sys) disable iff (reset)
      (busy_r && !e.start && divisible) |=> busy_r && (exp_r == $past(exp_r) + 8'h01);
   endproperty
   a_no_factor_left: assert property (p_no_factor_left)
      else $error("encoder stopped with a factor of ten left");
endmodule
`default_nettype wire

/* nand_target_init.sv */
// flash target discovery and init logic with chained enables, plus extended ecc fields
// assumes commands arrive as one-cycle strobes synchronous to clk_sys
//
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module nand_target_init
#(
   parameter int RESET_BUSY_CYC  = nand_init_pkg::RESET_BUSY_CYC,
   parameter int FEAT_SETTLE_CYC = nand_init_pkg::FEAT_SETTLE_CYC
)
(
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        reset,
   // register port
   input  wire logic [3:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_we,
   input  wire logic        reg_re,
   output logic      [31:0] reg_rdata,
   // target command port
   input  wire logic        host_enable_n,
   input  wire logic        cmd_valid,
   input  wire logic [7:0]  cmd_code,
   input  wire logic [7:0]  cmd_addr,
   input  wire logic [7:0]  cmd_data,
   // chain and status
   input  wire logic        chain_enable_in,
   output logic             chain_enable_out,
   output logic      [7:0]  status_byte
);
   localparam logic [nand_init_pkg::CNT_W-1:0] RESET_LOAD  =
      nand_init_pkg::CNT_W'(RESET_BUSY_CYC - 1);
   localparam logic [nand_init_pkg::CNT_W-1:0] SETTLE_LOAD =
      nand_init_pkg::CNT_W'(FEAT_SETTLE_CYC - 1);

   nand_init_pkg::tgt_state_t state_r, state_nxt;
   logic [nand_init_pkg::CNT_W-1:0] cnt_r;
   logic [31:0] ecc_info_r;
   logic [31:0] end_cycles_r;
   logic [7:0]  volume_r;
   logic [3:0]  timing_r;
   logic        seq_mode_r;
   logic        chain_out_r;
   logic [7:0]  status_r;
   logic [31:0] rdata_r;

   endurance_if enc_bus ();

   endurance_encoder u_enc
   (
      .clk_sys (clk_sys),
      .reset   (reset),
      .e       (enc_bus)
   );

   // command decode
   wire cmd_in     = cmd_valid && !host_enable_n;
   wire is_reset   = cmd_in && (cmd_code == nand_init_pkg::CMD_RESET);
   wire is_status  = cmd_in && (cmd_code == nand_init_pkg::CMD_READ_STATUS);
   wire is_setfeat = cmd_in && (cmd_code == nand_init_pkg::CMD_SET_FEATURES);
   wire is_volsel  = cmd_in && (cmd_code == nand_init_pkg::CMD_VOLUME_SELECT);
   wire feat_vol   = is_setfeat && (cmd_addr == nand_init_pkg::FEAT_VOLUME_CFG);
   wire feat_tim   = is_setfeat && (cmd_addr == nand_init_pkg::FEAT_TIMING);
   wire cnt_done   = (cnt_r == '0);
   wire busy       = (state_r == nand_init_pkg::ST_RESETTING) ||
                     (state_r == nand_init_pkg::ST_SETTLING);
   wire pre_app    = (state_r == nand_init_pkg::ST_READY) && chain_enable_in;
   wire live       = pre_app || (state_r == nand_init_pkg::ST_SELECTED);
   wire vol_hit    = is_volsel && (cmd_addr == volume_r);
   wire settle_end = (state_r == nand_init_pkg::ST_SETTLING) && cnt_done;
   wire load_reset = (state_nxt == nand_init_pkg::ST_RESETTING) &&
                     (state_r != nand_init_pkg::ST_RESETTING);
   wire load_feat  = (state_nxt == nand_init_pkg::ST_SETTLING) &&
                     (state_r != nand_init_pkg::ST_SETTLING);

   // register decode
   wire wr_ecc = reg_we && (reg_addr == nand_init_pkg::REG_ECC_INFO);
   wire wr_end = reg_we && (reg_addr == nand_init_pkg::REG_END_CYCLES);
   wire [31:0] rd_end_code = {14'h0000, enc_bus.ovf, enc_bus.busy, enc_bus.exponent,
                              enc_bus.value};
   wire [31:0] rd_target = {12'h000, timing_r, volume_r, 2'b00, chain_out_r, seq_mode_r,
                            1'b0, state_r};
   wire [31:0] rd_mux =
      (reg_addr == nand_init_pkg::REG_ECC_INFO)   ? ecc_info_r   :
      (reg_addr == nand_init_pkg::REG_END_CYCLES) ? end_cycles_r :
      (reg_addr == nand_init_pkg::REG_END_CODE)   ? rd_end_code  :
      (reg_addr == nand_init_pkg::REG_TARGET)     ? rd_target    : '0;

   assign enc_bus.start  = wr_end;
   assign enc_bus.cycles = reg_wdata;

   always_comb
   begin
      state_nxt = state_r;
      unique case (state_r)
         nand_init_pkg::ST_POWERON:
            if (is_reset)
               state_nxt = nand_init_pkg::ST_RESETTING;
            else if (is_status)
               state_nxt = nand_init_pkg::ST_WAIT_SEQ;
         nand_init_pkg::ST_WAIT_SEQ:
            if (is_reset && chain_enable_in)
               state_nxt = nand_init_pkg::ST_RESETTING;
         nand_init_pkg::ST_RESETTING:
            if (cnt_done)
               state_nxt = nand_init_pkg::ST_READY;
         nand_init_pkg::ST_READY:
            if (pre_app && is_reset)
               state_nxt = nand_init_pkg::ST_RESETTING;
            else if (pre_app && feat_vol)
               state_nxt = nand_init_pkg::ST_SETTLING;
         nand_init_pkg::ST_SETTLING:
            if (cnt_done)
               state_nxt = nand_init_pkg::ST_DESELECTED;
         nand_init_pkg::ST_DESELECTED:
            if (vol_hit)
               state_nxt = nand_init_pkg::ST_SELECTED;
         nand_init_pkg::ST_SELECTED:
            if (is_volsel && !vol_hit)
               state_nxt = nand_init_pkg::ST_DESELECTED;
            else if (is_reset)
               state_nxt = nand_init_pkg::ST_RESETTING;
         default:
            state_nxt = nand_init_pkg::ST_POWERON;
      endcase
   end

   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         state_r <= nand_init_pkg::ST_POWERON;
         cnt_r   <= '0;
      end
      else
      begin
         state_r <= state_nxt;
         cnt_r   <= load_reset ? RESET_LOAD : load_feat ? SETTLE_LOAD :
                    cnt_done   ? cnt_r : cnt_r - 1'b1;
      end
   end

   // target configuration
   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         seq_mode_r  <= 1'b0;
         volume_r    <= nand_init_pkg::VOLUME_RST;
         timing_r    <= nand_init_pkg::TIMING_MODE0;
         chain_out_r <= 1'b0;
      end
      else
      begin
         if ((state_r == nand_init_pkg::ST_POWERON) && is_status)
            seq_mode_r <= 1'b1;
         if (pre_app && feat_vol)
            volume_r <= cmd_data;
         if (live && feat_tim)
            timing_r <= cmd_data[3:0];
         if (settle_end)
            chain_out_r <= 1'b1;
      end
   end

   // registers and status byte
   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         ecc_info_r   <= nand_init_pkg::ECC_INFO_RST;
         end_cycles_r <= nand_init_pkg::END_CYCLES_RST;
         rdata_r      <= '0;
         status_r     <= '0;
      end
      else
      begin
         if (wr_ecc)
            ecc_info_r <= reg_wdata;
         if (wr_end)
            end_cycles_r <= reg_wdata;
         rdata_r  <= reg_re ? rd_mux : '0;
         status_r <= '0;
         status_r[nand_init_pkg::STATUS_READY_BIT] <= !busy;
      end
   end

   assign reg_rdata        = rdata_r;
   assign chain_enable_out = chain_out_r;
   assign status_byte      = status_r;

   sequence s_first_reset;
      (state_r == nand_init_pkg::ST_POWERON) && is_reset;
   endsequence
   sequence s_reset_busy;
      (state_r == nand_init_pkg::ST_RESETTING) [*2];
   endsequence

   property p_parallel_reset;
      @(posedge clk_sys) disable iff (reset)
      s_first_reset |=> s_reset_busy ##1 !status_r[nand_init_pkg::STATUS_READY_BIT];
   endproperty
   a_parallel_reset: assert property (p_parallel_reset)
      else $error("first reset not accepted by chained target");

   property p_seq_select;
      @(posedge clk_sys) disable iff (reset)
      ((state_r == nand_init_pkg::ST_POWERON) && is_status) |=>
         seq_mode_r && (state_r == nand_init_pkg::ST_WAIT_SEQ);
   endproperty
   a_seq_select: assert property (p_seq_select)
      else $error("first status read did not select sequential reset");

   property p_seq_gated;
      @(posedge clk_sys) disable iff (reset)
      ((state_r == nand_init_pkg::ST_WAIT_SEQ) && is_reset && !chain_enable_in) |=>
         (state_r == nand_init_pkg::ST_WAIT_SEQ);
   endproperty
   a_seq_gated: assert property (p_seq_gated)
      else $error("reset taken with chain enable input low");

   property p_appoint_done;
      @(posedge clk_sys) disable iff (reset)
      settle_end |=> chain_enable_out && (state_r == nand_init_pkg::ST_DESELECTED);
   endproperty
   a_appoint_done: assert property (p_appoint_done)
      else $error("appointment end did not raise chain enable out");

   property p_chain_out_late;
      @(posedge clk_sys) disable iff (reset)
      $rose(chain_enable_out) |-> $past(state_r) == nand_init_pkg::ST_SETTLING;
   endproperty
   a_chain_out_late: assert property (p_chain_out_late)
      else $error("chain enable out rose outside appointment");

   property p_mode0;
      @(posedge clk_sys)
      $fell(reset) |-> (timing_r == nand_init_pkg::TIMING_MODE0) && !chain_enable_out;
   endproperty
   a_mode0: assert property (p_mode0)
      else $error("timing mode not zero after power-up");

   property p_badmax_read;
      @(posedge clk_sys) disable iff (reset)
      (reg_re && (reg_addr == nand_init_pkg::REG_ECC_INFO)) |=>
         reg_rdata[31:nand_init_pkg::ECC_BADMAX_LSB] ==
         $past(ecc_info_r[31:nand_init_pkg::ECC_BADMAX_LSB]);
   endproperty
   a_badmax_read: assert property (p_badmax_read)
      else $error("bad block maximum field misread");

   property p_endurance_read;
      @(posedge clk_sys) disable iff (reset)
      (reg_re && (reg_addr == nand_init_pkg::REG_END_CODE)) |=>
         (reg_rdata[7:0] == $past(enc_bus.value)) &&
         (reg_rdata[15:nand_init_pkg::END_EXP_LSB] == $past(enc_bus.exponent));
   endproperty
   a_endurance_read: assert property (p_endurance_read)
      else $error("endurance bytes misplaced");
endmodule
`default_nettype wire

/* host_model.sv */
// host sequencer model driving one host enable line and its command strobes
// assumes clk_sys and a registered status byte from the target
`timescale 1ns/1ps
`default_nettype none
module host_model
#(
   parameter int SETTLE_CYC = 4,
   parameter int POLL_MAX   = 64
)
(
   // clock
   input  wire logic       clk_sys,
   // target command port
   output logic            host_enable_n,
   output logic            cmd_valid,
   output logic      [7:0] cmd_code,
   output logic      [7:0] cmd_addr,
   output logic      [7:0] cmd_data,
   input  wire logic [7:0] status_byte,
   // probe outcome
   output logic            timed_out
);
   // set when the first-bus probe times out, just before the second-bus retry
   logic on_bus2;
   // line given up after both buses failed
   logic line_dead;

   initial
   begin
      on_bus2       = 1'b0;
      line_dead     = 1'b0;
      host_enable_n = 1'b1;
      cmd_valid     = 1'b0;
      cmd_code      = 8'h00;
      cmd_addr      = 8'h00;
      cmd_data      = 8'h00;
      timed_out     = 1'b0;
   end

   // one command strobe; released lines show the inverse so stale values never match
   task automatic send(input logic [7:0] code, input logic [7:0] addr, input logic [7:0] data);
      @(posedge clk_sys);
      cmd_valid <= 1'b1;
      cmd_code  <= code;
      cmd_addr  <= addr;
      cmd_data  <= data;
      @(posedge clk_sys);
      cmd_valid <= 1'b0;
      cmd_code  <= ~code;
      cmd_addr  <= ~addr;
      cmd_data  <= ~data;
   endtask

   // only this line is pulled low, held low through appointment
   task automatic enable(input logic lvl_n);
      @(posedge clk_sys);
      host_enable_n <= lvl_n;
   endtask

   // poll with read status under a bounded count; expiry marks the probe failed
   task automatic poll_ready();
      bit ok;
      ok = 1'b0;
      for (int i = 0; i < POLL_MAX && !ok; i++)
      begin
         send(nand_init_pkg::CMD_READ_STATUS, 8'h00, 8'h00);
         #1;
         ok = (status_byte[nand_init_pkg::STATUS_READY_BIT] === 1'b1);
      end
      timed_out = !ok;
   endtask

   // a failed first-bus probe is repeated once on the second bus before giving up
   task automatic retry_second_bus();
      if (timed_out)
      begin
         on_bus2 = 1'b1;
         send(nand_init_pkg::CMD_RESET, 8'h00, 8'h00);
         poll_ready();
      end
      line_dead = timed_out;
   endtask

   // appoint a volume, then stay silent until the settle time is over
   task automatic appoint(input logic [7:0] vol);
      send(nand_init_pkg::CMD_SET_FEATURES, nand_init_pkg::FEAT_VOLUME_CFG, vol);
      repeat (SETTLE_CYC + 4) @(posedge clk_sys);
   endtask

   // finish with a volume select after the enable goes high then low
   task automatic select_vol(input logic [7:0] vol);
      enable(1'b1);
      enable(1'b0);
      send(nand_init_pkg::CMD_VOLUME_SELECT, vol, 8'h00);
   endtask
endmodule
`default_nettype wire

/* tb_top.sv */
// self-checking bench for the flash target init block
// assumes shortened busy and settle counts of four cycles
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam int BUSY = 4;
   localparam logic [31:0] END_IN [4] = '{32'h0001_24F8, 32'h0001_86A0, 32'h0000_00FA,
                                          32'h0000_00FF};
   localparam logic [31:0] END_EX [4] = '{32'h0000_034B, 32'h0000_0501, 32'h0000_0119,
                                          32'h0000_00FF};
   logic        clk_sys = 1'b0;
   logic        reset   = 1'b1;
   logic [3:0]  reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic        reg_we = 1'b0;
   logic        reg_re = 1'b0;
   logic [31:0] reg_rdata;
   logic        host_enable_n, cmd_valid, timed_out;
   logic [7:0]  cmd_code, cmd_addr, cmd_data, status_byte;
   logic        chain_enable_in = 1'b0;
   logic        chain_enable_out;
   int          failures = 0;
   int          n_compared = 0;

   always #2 clk_sys = ~clk_sys;

   nand_target_init #(.RESET_BUSY_CYC(BUSY), .FEAT_SETTLE_CYC(BUSY)) u_nand_target_init
   (
      .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
      .host_enable_n(host_enable_n), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
      .cmd_addr(cmd_addr), .cmd_data(cmd_data), .chain_enable_in(chain_enable_in),
      .chain_enable_out(chain_enable_out), .status_byte(status_byte)
   );

   host_model #(.SETTLE_CYC(BUSY)) u_host_model
   (
      .clk_sys(clk_sys), .host_enable_n(host_enable_n), .cmd_valid(cmd_valid),
      .cmd_code(cmd_code), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
      .status_byte(status_byte), .timed_out(timed_out)
   );

   task automatic chk(input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp)
      begin
         failures++;
         $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_we    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_we    <= 1'b0;
      reg_wdata <= ~d;
   endtask

   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      reg_re   <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_re   <= 1'b0;
      #1;
      d = reg_rdata;
   endtask

   task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
      logic [31:0] d;
      rd(a, d);
      chk(exp, d);
   endtask

   // status bit must be low two cycles after an accepted reset
   task automatic chk_busy();
      repeat (2) @(posedge clk_sys);
      #1;
      chk(32'h0, {24'h0, status_byte});
   endtask

   task automatic t_power_on();
      chk(32'h40, {24'h0, status_byte});
      rd_chk(nand_init_pkg::REG_TARGET, 32'h0);
      rd_chk(nand_init_pkg::REG_ECC_INFO, nand_init_pkg::ECC_INFO_RST);
   endtask

   task automatic t_ecc_regs();
      wr(nand_init_pkg::REG_ECC_INFO, 32'h01F4_0918);
      rd_chk(nand_init_pkg::REG_ECC_INFO, 32'h01F4_0918);
      rd_chk(4'h2, 32'h0);
   endtask

   task automatic t_endurance();
      logic [31:0] d;
      for (int k = 0; k < 4; k++)
      begin
         wr(nand_init_pkg::REG_END_CYCLES, END_IN[k]);
         for (int i = 0; i < 20; i++)
         begin
            rd(nand_init_pkg::REG_END_CODE, d);
            if (d[nand_init_pkg::END_BUSY_BIT] === 1'b0)
               break;
         end
         chk(END_EX[k], d);
      end
      wr(nand_init_pkg::REG_END_CODE, 32'h0);
      rd_chk(nand_init_pkg::REG_END_CODE, END_EX[3]);
   endtask

   task automatic t_parallel();
      u_host_model.enable(1'b0);
      u_host_model.send(nand_init_pkg::CMD_RESET, 8'h00, 8'h00);
      chk_busy();
      u_host_model.poll_ready();
      chk(32'h0, {31'h0, timed_out});
      u_host_model.retry_second_bus();
      chk(32'h0, {30'h0, u_host_model.on_bus2, u_host_model.line_dead});
      rd_chk(nand_init_pkg::REG_TARGET, 32'h0000_0003);
      u_host_model.send(nand_init_pkg::CMD_SET_FEATURES, nand_init_pkg::FEAT_VOLUME_CFG, 8'h5A);
      rd_chk(nand_init_pkg::REG_TARGET, 32'h0000_0003);
      @(posedge clk_sys);
      chain_enable_in <= 1'b1;
      u_host_model.send(nand_init_pkg::CMD_SET_FEATURES, nand_init_pkg::FEAT_VOLUME_CFG, 8'h5A);
      u_host_model.send(nand_init_pkg::CMD_RESET, 8'h00, 8'h00);
      repeat (BUSY + 4) @(posedge clk_sys);
      rd_chk(nand_init_pkg::REG_TARGET, 32'h0000_5A25);
      chk(32'h1, {31'h0, chain_enable_out});
      u_host_model.send(nand_init_pkg::CMD_VOLUME_SELECT, 8'h5B, 8'h00);
      rd_chk(nand_init_pkg::REG_TARGET, 32'h0000_5A25);
      u_host_model.select_vol(8'h5A);
      rd_chk(nand_init_pkg::REG_TARGET, 32'h0000_5A26);
      u_host_model.send(nand_init_pkg::CMD_SET_FEATURES, nand_init_pkg::FEAT_TIMING, 8'h03);
      rd_chk(nand_init_pkg::REG_TARGET, 32'h0003_5A26);
   endtask

   task automatic t_sequential();
      @(posedge clk_sys);
      reset           <= 1'b1;
      chain_enable_in <= 1'b0;
      repeat (2) @(posedge clk_sys);
      reset <= 1'b0;
      u_host_model.enable(1'b1);
      u_host_model.send(nand_init_pkg::CMD_RESET, 8'h00, 8'h00);
      rd_chk(nand_init_pkg::REG_TARGET, 32'h0);
      chk(32'h0, {31'h0, chain_enable_out});
      u_host_model.enable(1'b0);
      u_host_model.send(nand_init_pkg::CMD_READ_STATUS, 8'h00, 8'h00);
      rd_chk(nand_init_pkg::REG_TARGET, 32'h0000_0011);
      u_host_model.send(nand_init_pkg::CMD_RESET, 8'h00, 8'h00);
      rd_chk(nand_init_pkg::REG_TARGET, 32'h0000_0011);
      @(posedge clk_sys);
      chain_enable_in <= 1'b1;
      u_host_model.send(nand_init_pkg::CMD_RESET, 8'h00, 8'h00);
      chk_busy();
      u_host_model.poll_ready();
      chk(32'h0, {31'h0, timed_out});
      rd_chk(nand_init_pkg::REG_TARGET, 32'h0000_0013);
      u_host_model.appoint(8'h33);
      rd_chk(nand_init_pkg::REG_TARGET, 32'h0000_3335);
   endtask

   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial
   begin
      #40000;
      failures++;
      conclude();
   end

   initial
   begin
      repeat (4) @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
      #1;
      t_power_on();
      t_ecc_regs();
      t_endurance();
      t_parallel();
      t_sequential();
      conclude();
   end
endmodule
`default_nettype wire
